// >>> verilog/bmbt_pkg.sv
package bmbt_pkg;

    // Register byte offsets (APB, one aligned word each)
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_FLAGS     = 8'h04;
    localparam logic [7:0] ADDR_TRACE_SEL = 8'h08;
    localparam logic [7:0] ADDR_SRC_Q     = 8'h0c;
    localparam logic [7:0] ADDR_DST_Q     = 8'h10;
    localparam logic [7:0] ADDR_VALID     = 8'h14;
    localparam logic [7:0] ADDR_CH_BASE   = 8'h40;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h20;
    // Per-channel word offsets within a channel block
    localparam logic [7:0] CH_ADDR        = 8'h00;
    localparam logic [7:0] CH_AMASK       = 8'h04;
    localparam logic [7:0] CH_DATA        = 8'h08;
    localparam logic [7:0] CH_DMASK       = 8'h0c;
    localparam logic [7:0] CH_CYCLE       = 8'h10;
    localparam logic [7:0] CH_COUNT       = 8'h14;

    // Cycle select field positions
    localparam int CS_MASTER_LSB = 0;
    localparam int CS_KIND_LSB   = 2;
    localparam int CS_DIR_LSB    = 4;
    localparam int CS_SIZE_LSB   = 6;

    // Two-bit selector encodings
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_A     = 2'h1;
    localparam logic [1:0] SEL_B     = 2'h2;
    localparam logic [1:0] SEL_EITHR = 2'h3;

    // Access sizes
    localparam logic [1:0] SZ_ANY  = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    // Per-channel control bits (nibble per channel in ctrl register)
    localparam int CTRL_AFTER = 0;
    localparam int CTRL_DATA  = 1;
    localparam int CTRL_COUNT = 2;

    localparam int        NUM_CH    = 4;
    localparam int        TRACE_LEN = 4;
    localparam logic [3:0] BREAK_PRIORITY = 4'hf;

endpackage

// >>> verilog/bmbt_chan_match.sv
`timescale 1ns/1ps
module bmbt_chan_match #(
    parameter bit HAS_DATA = 1'b0
) (
    // Channel settings
    input  wire logic [31:0] brk_addr,
    input  wire logic [31:0] addr_mask,
    input  wire logic [31:0] brk_data,
    input  wire logic [31:0] data_mask,
    input  wire logic [7:0]  cycle_sel,
    input  wire logic        data_en,
    // Observed bus cycle
    input  wire logic        cyc_valid,
    input  wire logic        cyc_dma,
    input  wire logic        cyc_fetch,
    input  wire logic        cyc_write,
    input  wire logic [1:0]  cyc_size,
    input  wire logic [31:0] cyc_addr,
    input  wire logic [31:0] cyc_data,
    input  wire logic        cyc_excluded,
    // Result
    output logic             hit,
    output logic             is_fetch_sel
);

    function automatic logic sel_ok(input logic [1:0] sel, input logic second);
        sel_ok = (sel == bmbt_pkg::SEL_EITHR) ||
                 (sel == bmbt_pkg::SEL_A && !second) ||
                 (sel == bmbt_pkg::SEL_B && second);
    endfunction

    logic [1:0]  m_sel;
    logic [1:0]  k_sel;
    logic [1:0]  d_sel;
    logic [1:0]  s_sel;
    logic [31:0] cmp_mask;
    logic        addr_ok;
    logic        data_ok;

    always_comb
    begin
        m_sel = cycle_sel[bmbt_pkg::CS_MASTER_LSB +: 2];
        k_sel = cycle_sel[bmbt_pkg::CS_KIND_LSB +: 2];
        d_sel = cycle_sel[bmbt_pkg::CS_DIR_LSB +: 2];
        s_sel = cycle_sel[bmbt_pkg::CS_SIZE_LSB +: 2];
        is_fetch_sel = (k_sel == bmbt_pkg::SEL_A);
        // Low address bits dropped by access size
        cmp_mask = ~addr_mask;
        if (cyc_size == bmbt_pkg::SZ_LONG)
        begin
            cmp_mask[1:0] = 2'h0; // [RQ17]
        end
        else if (cyc_size == bmbt_pkg::SZ_WORD)
        begin
            cmp_mask[0] = 1'b0; // [RQ17]
        end
        addr_ok = ((brk_addr ^ cyc_addr) & cmp_mask) == 32'h0; // [RQ18]
        // Fetch channels ignore the data comparison
        data_ok = !HAS_DATA || !data_en || is_fetch_sel ||
                  (((brk_data ^ cyc_data) & ~data_mask) == 32'h0); // [RQ14] [RQ18]
        // A master, kind or direction selector at 00 disables the channel; size 00 means any size
        hit = cyc_valid && !cyc_excluded &&
              m_sel != bmbt_pkg::SEL_NONE && k_sel != bmbt_pkg::SEL_NONE &&
              d_sel != bmbt_pkg::SEL_NONE && // [RQ5]
              sel_ok(m_sel, cyc_dma) && sel_ok(k_sel, !cyc_fetch) &&
              sel_ok(d_sel, cyc_write) &&
              (s_sel == bmbt_pkg::SZ_ANY || s_sel == cyc_size) &&
              addr_ok && data_ok;
    end

endmodule

// >>> verilog/bmbt_trace_queue.sv
`timescale 1ns/1ps
module bmbt_trace_queue #(
    parameter int DEPTH = 4
) (
    // Clock
    input  wire logic        core_clk,
    // Push
    input  wire logic        push,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] dst_in,
    // Read port
    input  wire logic [1:0]  sel,
    output logic      [31:0] src_out,
    output logic      [31:0] dst_out
);

    initial
    begin
        if (DEPTH != 4)
        begin
            $error("trace depth must be 4");
        end
    end

    // No reset: contents stay undefined until branches arrive
    logic [31:0] src_q [DEPTH];
    logic [31:0] dst_q [DEPTH];

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            src_q[0] <= src_in; // [RQ1] [RQ2] [RQ21]
            dst_q[0] <= dst_in; // [RQ3] [RQ4] [RQ21]
            for (int i = 1; i < DEPTH; i++)
            begin
                src_q[i] <= src_q[i-1];
                dst_q[i] <= dst_q[i-1];
            end
        end
    end

    assign src_out = src_q[sel];
    assign dst_out = dst_q[sel];

endmodule

// >>> verilog/bmbt_top.sv
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Four-deep source trace queue, shifts per branch
// RQ2 - Source queue never reset
// RQ3 - Four-deep destination queue, shifts per branch
// RQ4 - Destination queue never reset
// RQ5 - Master, kind or direction selector 00 disables channel
// RQ6 - Match raises interrupt, sets master flag
// RQ7 - Break request carries priority fifteen
// RQ8 - Flags hardware-set, software-cleared by zero
// RQ9 - Channels three/four may wait for count
// RQ10 - Fetch break only after execution (CTRL_AFTER unused)
// RQ11 - Discarded fetches never break
// RQ12 - Blocked slots defer to next acceptance
// RQ13 - Fetch break fires post-completion, deferred similarly
// RQ14 - Fetch channels ignore data compare
// RQ15 - Fetch break only on start address
// RQ16 - Excluded cycle kinds never match
// RQ17 - Address compare trimmed by size
// RQ18 - Masked address and data comparison
// RQ19 - Source valid set on fetch, read-cleared
// RQ20 - Destination valid set, read-cleared
// RQ21 - Queues push together, stay aligned
module bmbt_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Observed bus cycle
    input  wire logic        cyc_valid,
    input  wire logic        cyc_dma,
    input  wire logic        cyc_fetch,
    input  wire logic        cyc_write,
    input  wire logic [1:0]  cyc_size,
    input  wire logic [31:0] cyc_addr,
    input  wire logic [31:0] cyc_data,
    input  wire logic        cyc_excluded,
    // Instruction execution status
    input  wire logic        insn_exec,
    input  wire logic        insn_discard,
    input  wire logic        insn_int_ok,
    // Branch trace
    input  wire logic        branch_taken,
    input  wire logic [31:0] branch_src,
    input  wire logic [31:0] branch_dst,
    input  wire logic        dst_fetched,
    // Interrupt arbiter
    output logic             break_req,
    output logic [3:0]       break_level,
    input  wire logic        break_ack
);

    typedef enum logic [1:0] {FS_IDLE, FS_WAIT_EXEC, FS_DEFER} bmbt_fstate_t;

    typedef struct packed {
        logic [15:0]  ctrl;
        logic [7:0]   cpu_flag;
        logic [3:0]   dma_flag;
        logic [1:0]   trace_sel;
        logic         src_valid;
        logic         dst_valid;
        logic         pend;
        logic [31:0]  rdata;
        logic [3:0][31:0] b_addr;
        logic [3:0][31:0] b_amask;
        logic [1:0][31:0] b_data;
        logic [1:0][31:0] b_dmask;
        logic [3:0][7:0]  b_cycle;
        logic [1:0][11:0] b_target;
        logic [1:0][11:0] b_count;
        logic [3:0][1:0]  fst;
        logic [3:0]   fdma;
    } bmbt_state_t;

    bmbt_state_t st_reg;
    bmbt_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////

    logic [3:0]  raw_hit;
    logic [3:0]  is_fetch;
    logic [31:0] q_src;
    logic [31:0] q_dst;

    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        bmbt_chan_match #(
            .HAS_DATA (c >= 2)
        ) u_match (
            .brk_addr     (st_reg.b_addr[c]),
            .addr_mask    (st_reg.b_amask[c]),
            .brk_data     (c >= 2 ? st_reg.b_data[c%2] : 32'h0),
            .data_mask    (c >= 2 ? st_reg.b_dmask[c%2] : 32'h0),
            .cycle_sel    (st_reg.b_cycle[c]),
            .data_en      (st_reg.ctrl[c*4 + bmbt_pkg::CTRL_DATA]),
            .cyc_valid    (cyc_valid),
            .cyc_dma      (cyc_dma),
            .cyc_fetch    (cyc_fetch),
            .cyc_write    (cyc_write),
            .cyc_size     (cyc_size),
            .cyc_addr     (cyc_addr),
            .cyc_data     (cyc_data),
            .cyc_excluded (cyc_excluded), // [RQ16]
            .hit          (raw_hit[c]),
            .is_fetch_sel (is_fetch[c])
        );
    end

    bmbt_trace_queue #(
        .DEPTH (bmbt_pkg::TRACE_LEN)
    ) u_trace (
        .core_clk (core_clk),
        .push     (branch_taken),
        .src_in   (branch_src),
        .dst_in   (branch_dst),
        .sel      (st_reg.trace_sel),
        .src_out  (q_src),
        .dst_out  (q_dst)
    );

    ////////////////////////////////////////////////////////////////////////////

    logic        acc;
    logic        wr;
    logic [3:0]  ch_fire;
    logic [3:0]  ch_dma;
    logic [2:0]  ch_idx;
    logic [7:0]  ch_off;

    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign break_req   = st_reg.pend;
    assign break_level = bmbt_pkg::BREAK_PRIORITY; // [RQ7]

    always_comb
    begin
        st_next  = st_reg;
        ch_fire  = 4'h0;
        ch_dma   = 4'h0;
        ch_idx   = 3'(paddr[7:5] - 3'h2);
        ch_off   = {3'h0, paddr[4:0]};

        // Fetch sequencing: wait for execution, then an interrupt-accepting point
        for (int c = 0; c < 4; c++)
        begin
            case (bmbt_bfs(st_reg.fst[c]))
                FS_IDLE:
                begin
                    if (raw_hit[c] && is_fetch[c])
                    begin
                        st_next.fst[c] = 2'(FS_WAIT_EXEC); // [RQ10] [RQ15]
                        st_next.fdma[c] = cyc_dma;
                    end
                    else if (raw_hit[c])
                    begin
                        ch_fire[c] = 1'b1;
                        ch_dma[c]  = cyc_dma;
                    end
                end
                FS_WAIT_EXEC:
                begin
                    if (insn_discard)
                    begin
                        st_next.fst[c] = 2'(FS_IDLE); // [RQ11]
                    end
                    else if (insn_exec)
                    begin
                        // Execution seen; every fetch channel now waits for acceptance (CTRL_AFTER is not used)
                        st_next.fst[c] = 2'(FS_DEFER); // [RQ11] [RQ13]
                    end
                end
                FS_DEFER:
                begin
                    if (insn_int_ok)
                    begin
                        ch_fire[c] = 1'b1; // [RQ12] [RQ13]
                        ch_dma[c]  = st_reg.fdma[c];
                        st_next.fst[c] = 2'(FS_IDLE);
                    end
                end
                default:
                begin
                    st_next.fst[c] = 2'(FS_IDLE);
                end
            endcase
        end

        // Execution counts on channels three and four
        for (int k = 0; k < 2; k++)
        begin
            if (st_reg.ctrl[(k+2)*4 + bmbt_pkg::CTRL_COUNT] && ch_fire[k+2])
            begin
                st_next.b_count[k] = 12'(st_reg.b_count[k] + 12'h1);
                if (12'(st_reg.b_count[k] + 12'h1) != st_reg.b_target[k])
                begin
                    ch_fire[k+2] = 1'b0; // [RQ9]
                end
                else
                begin
                    st_next.b_count[k] = 12'h0;
                end
            end
        end

        // Register writes; zero clears a flag
        if (wr)
        begin
            case (paddr)
                bmbt_pkg::ADDR_CTRL:      st_next.ctrl = pwdata[15:0];
                bmbt_pkg::ADDR_FLAGS:
                begin
                    st_next.cpu_flag = st_reg.cpu_flag & pwdata[7:0]; // [RQ8]
                    st_next.dma_flag = st_reg.dma_flag & pwdata[11:8]; // [RQ8]
                end
                bmbt_pkg::ADDR_TRACE_SEL: st_next.trace_sel = pwdata[1:0];
                default:
                begin
                    if (paddr >= bmbt_pkg::ADDR_CH_BASE && !ch_idx[2])
                    begin
                        case (ch_off)
                            bmbt_pkg::CH_ADDR:  st_next.b_addr[ch_idx[1:0]] = pwdata;
                            bmbt_pkg::CH_AMASK: st_next.b_amask[ch_idx[1:0]] = pwdata;
                            bmbt_pkg::CH_CYCLE: st_next.b_cycle[ch_idx[1:0]] = pwdata[7:0];
                            bmbt_pkg::CH_DATA:
                                if (ch_idx[1]) st_next.b_data[ch_idx[0]] = pwdata;
                            bmbt_pkg::CH_DMASK:
                                if (ch_idx[1]) st_next.b_dmask[ch_idx[0]] = pwdata;
                            bmbt_pkg::CH_COUNT:
                                if (ch_idx[1]) st_next.b_target[ch_idx[0]] = pwdata[11:0];
                            default: ;
                        endcase
                    end
                end
            endcase
        end

        // Flags set by hardware win over clears
        for (int c = 0; c < 4; c++)
        begin
            if (ch_fire[c])
            begin
                if (ch_dma[c])
                begin
                    st_next.dma_flag[c] = 1'b1; // [RQ6] [RQ8]
                end
                else
                begin
                    st_next.cpu_flag[c] = 1'b1; // [RQ6] [RQ8]
                end
            end
        end

        // Request held until the arbiter accepts it
        if (|ch_fire)
        begin
            st_next.pend = 1'b1; // [RQ6] [RQ7]
        end
        else if (break_ack)
        begin
            st_next.pend = 1'b0;
        end

        // Read data capture and read side effects
        st_next.rdata = 32'h0;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                bmbt_pkg::ADDR_CTRL:      st_next.rdata = {16'h0, st_reg.ctrl};
                bmbt_pkg::ADDR_FLAGS:     st_next.rdata = {20'h0, st_reg.dma_flag,
                                                           4'h0, st_reg.cpu_flag[3:0]};
                bmbt_pkg::ADDR_TRACE_SEL: st_next.rdata = {30'h0, st_reg.trace_sel};
                bmbt_pkg::ADDR_SRC_Q:     st_next.rdata = q_src;
                bmbt_pkg::ADDR_DST_Q:     st_next.rdata = q_dst;
                bmbt_pkg::ADDR_VALID:     st_next.rdata = {30'h0, st_reg.dst_valid,
                                                           st_reg.src_valid};
                default:
                begin
                    if (paddr >= bmbt_pkg::ADDR_CH_BASE && !ch_idx[2])
                    begin
                        case (ch_off)
                            bmbt_pkg::CH_ADDR:  st_next.rdata = st_reg.b_addr[ch_idx[1:0]];
                            bmbt_pkg::CH_AMASK: st_next.rdata = st_reg.b_amask[ch_idx[1:0]];
                            bmbt_pkg::CH_CYCLE: st_next.rdata = {24'h0,
                                                                 st_reg.b_cycle[ch_idx[1:0]]};
                            default: ;
                        endcase
                    end
                end
            endcase
        end
        if (acc && !pwrite && paddr == bmbt_pkg::ADDR_SRC_Q)
        begin
            st_next.src_valid = 1'b0; // [RQ19]
        end
        if (acc && !pwrite && paddr == bmbt_pkg::ADDR_DST_Q)
        begin
            st_next.dst_valid = 1'b0; // [RQ20]
        end
        // Fetch of the destination wins over a concurrent read
        if (dst_fetched)
        begin
            st_next.src_valid = 1'b1; // [RQ19]
            st_next.dst_valid = 1'b1; // [RQ20]
        end
        st_next.cpu_flag[7:4] = 4'h0;
    end

    function automatic bmbt_fstate_t bmbt_bfs(input logic [1:0] v);
        bmbt_bfs = bmbt_fstate_t'(v);
    endfunction

    assign pslverr = 1'b0;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    chk_flag_sticky: assert property (@(posedge core_clk) disable iff (rst) // [RQ8]
        ($past(st_reg.cpu_flag[3:0]) & ~st_reg.cpu_flag[3:0]) == 4'h0 ||
        $past(wr && paddr == bmbt_pkg::ADDR_FLAGS))
        else $error("cpu flag cleared without a write");

    chk_req_on_fire: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
        |ch_fire |=> break_req)
        else $error("match did not raise break request");

    chk_req_held: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
        break_req && !break_ack |=> break_req)
        else $error("pending break request lost");

    chk_level_fixed: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
        break_level == 4'hf)
        else $error("break level not fifteen");

    chk_disabled_ch: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
        st_reg.b_cycle[0][1:0] == 2'h0 |-> !raw_hit[0])
        else $error("disabled channel matched");

    sequence s_fetch_armed(int c);
        st_reg.fst[c] == 2'(FS_WAIT_EXEC) && insn_discard;
    endsequence
    chk_discard_drop: assert property (@(posedge core_clk) disable iff (rst) // [RQ11]
        s_fetch_armed(2) |=> st_reg.fst[2] == 2'(FS_IDLE) && !ch_fire[2])
        else $error("discarded fetch kept armed");

    chk_defer_wait: assert property (@(posedge core_clk) disable iff (rst) // [RQ12]
        st_reg.fst[2] == 2'(FS_DEFER) && !insn_int_ok |-> !ch_fire[2])
        else $error("deferred break fired early");

    chk_src_valid: assert property (@(posedge core_clk) disable iff (rst) // [RQ19]
        dst_fetched |=> st_reg.src_valid && st_reg.dst_valid)
        else $error("valid flags not set on fetch");

    chk_count_gate: assert property (@(posedge core_clk) disable iff (rst) // [RQ9]
        st_reg.ctrl[12 + bmbt_pkg::CTRL_COUNT] && ch_fire[3] |->
        12'(st_reg.b_count[1] + 12'h1) == st_reg.b_target[1])
        else $error("counted channel fired before target");

endmodule

// >>> verification/bmbt_arbiter_model.sv
`timescale 1ns/1ps
// Interrupt arbiter stand-in: takes the break once its level beats the mask
module bmbt_arbiter_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Break request side
    input  wire logic       break_req,
    input  wire logic [3:0] break_level,
    input  wire logic [3:0] mask_level,
    output logic            break_ack
);
    // Masked requests get no ack, so they stay pending and are not lost
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            break_ack <= 1'b0;
        else
            break_ack <= break_req && !break_ack && (break_level > mask_level);
    end
endmodule

// >>> verification/tb_bmbt_top.sv
`timescale 1ns/1ps
module tb_bmbt_top;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, break_req, break_ack;
    logic        cyc_valid = 1'b0, cyc_dma = 1'b0, cyc_fetch = 1'b0, cyc_write = 1'b0;
    logic [1:0]  cyc_size = 2'h0;
    logic [31:0] cyc_addr = 32'h0, cyc_data = 32'h0;
    logic        cyc_excluded = 1'b0, insn_exec = 1'b0, insn_discard = 1'b0;
    logic        insn_int_ok = 1'b0, branch_taken = 1'b0, dst_fetched = 1'b0;
    logic [31:0] branch_src = 32'h0, branch_dst = 32'h0, rd;
    logic [3:0]  break_level, mask_level = 4'he;
    int          err_total = 0, check_count = 0;
    logic [1:0]  sz[5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h2};
    logic [31:0] ad[5] = '{32'h1000, 32'h1002, 32'h1003, 32'h1002, 32'h1000};
    logic [31:0] ex[5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0};
    logic [31:0] cz[3] = '{32'h18, 32'h11, 32'h09};

    always #10 core_clk = ~core_clk;

    bmbt_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
        .cyc_write(cyc_write), .cyc_size(cyc_size), .cyc_addr(cyc_addr),
        .cyc_data(cyc_data), .cyc_excluded(cyc_excluded), .insn_exec(insn_exec),
        .insn_discard(insn_discard), .insn_int_ok(insn_int_ok),
        .branch_taken(branch_taken), .branch_src(branch_src), .branch_dst(branch_dst),
        .dst_fetched(dst_fetched), .break_req(break_req), .break_level(break_level),
        .break_ack(break_ack));

    bmbt_arbiter_model i_arb (.core_clk(core_clk), .rst(rst), .break_req(break_req),
        .break_level(break_level), .mask_level(mask_level), .break_ack(break_ack));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    // Zero-wait slave today, but the master still waits on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1 || pslverr !== 1'b0)
        begin
            $display("CHECK FAILED at %0t: bad bus response", $time);
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [7:0] ch(input int c, input logic [7:0] off);
        return bmbt_pkg::ADDR_CH_BASE + bmbt_pkg::ADDR_CH_STRIDE * 8'(c) + off;
    endfunction

    // Trailing idle edge keeps back-to-back calls from double-driving
    task automatic cyc(input logic dma, input logic f, input logic [1:0] s,
                       input logic [31:0] a, input logic [31:0] d, input logic x);
        @(posedge core_clk);
        cyc_valid <= 1'b1;
        cyc_dma <= dma;
        cyc_fetch <= f;
        cyc_size <= s;
        cyc_addr <= a;
        cyc_data <= d;
        cyc_excluded <= x;
        @(posedge core_clk);
        cyc_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic ev(input int k);
        @(posedge core_clk);
        insn_exec <= (k == 0);
        insn_discard <= (k == 1);
        dst_fetched <= (k == 2);
        @(posedge core_clk);
        {insn_exec, insn_discard, dst_fetched} <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        rdc(bmbt_pkg::ADDR_VALID, 32'h0);
        rdc(8'hfc, 32'h0);
        $display("test reset done");
        // Five pushes into a four-deep queue drop the oldest
        for (int i = 1; i <= 5; i++)
        begin
            @(posedge core_clk);
            branch_taken <= 1'b1;
            branch_src <= i * 32'h100;
            branch_dst <= i * 32'h100 + 32'h10;
        end
        @(posedge core_clk);
        branch_taken <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            wr(bmbt_pkg::ADDR_TRACE_SEL, 32'(s));
            rdc(bmbt_pkg::ADDR_SRC_Q, (5 - s) * 32'h100);
            rdc(bmbt_pkg::ADDR_DST_Q, (5 - s) * 32'h100 + 32'h10);
        end
        ev(2);
        rdc(bmbt_pkg::ADDR_VALID, 32'h3);
        rdc(bmbt_pkg::ADDR_SRC_Q, 32'h200);
        rdc(bmbt_pkg::ADDR_VALID, 32'h2);
        rdc(bmbt_pkg::ADDR_DST_Q, 32'h210);
        rdc(bmbt_pkg::ADDR_VALID, 32'h0);
        $display("test trace done");
        wr(ch(0, bmbt_pkg::CH_ADDR), 32'h1003);
        wr(ch(0, bmbt_pkg::CH_CYCLE), 32'h19);
        for (int k = 0; k < 5; k++)
        begin
            cyc(1'b0, 1'b0, sz[k], ad[k], 32'h0, 1'b0);
            rdc(bmbt_pkg::ADDR_FLAGS, ex[k]);
            wr(bmbt_pkg::ADDR_FLAGS, 32'h0);
        end
        cyc(1'b0, 1'b0, 2'h3, 32'h1000, 32'h0, 1'b0);
        wr(bmbt_pkg::ADDR_FLAGS, 32'hffffffff);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h1);
        wr(bmbt_pkg::ADDR_FLAGS, 32'h0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        cyc(1'b0, 1'b0, 2'h3, 32'h1000, 32'h0, 1'b1);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        $display("test data break done");
        wr(ch(1, bmbt_pkg::CH_ADDR), 32'h1100);
        for (int k = 0; k < 3; k++)
        begin
            wr(ch(1, bmbt_pkg::CH_CYCLE), cz[k]);
            cyc(1'b0, 1'b0, 2'h3, 32'h1100, 32'h0, 1'b0);
            rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        end
        wr(ch(1, bmbt_pkg::CH_CYCLE), 32'h1b);
        @(posedge core_clk);
        mask_level <= 4'hf;
        cyc(1'b1, 1'b0, 2'h3, 32'h1100, 32'h0, 1'b0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h200);
        repeat (4) @(posedge core_clk);
        chk({31'h0, break_req}, 32'h1);
        mask_level <= 4'he;
        repeat (4) @(posedge core_clk);
        chk({31'h0, break_req}, 32'h0);
        chk({28'h0, break_level}, 32'hf);
        wr(bmbt_pkg::ADDR_FLAGS, 32'h0);
        $display("test master and level done");
        // Data compare enabled on purpose: a fetch channel must ignore it
        wr(bmbt_pkg::ADDR_CTRL, 32'h200);
        wr(ch(2, bmbt_pkg::CH_ADDR), 32'h2000);
        wr(ch(2, bmbt_pkg::CH_DATA), 32'hffffffff);
        wr(ch(2, bmbt_pkg::CH_CYCLE), 32'h95);
        cyc(1'b0, 1'b1, 2'h2, 32'h2000, 32'h0, 1'b0);
        ev(0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        insn_int_ok <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h4);
        wr(bmbt_pkg::ADDR_FLAGS, 32'h0);
        cyc(1'b0, 1'b1, 2'h2, 32'h2000, 32'h0, 1'b0);
        ev(1);
        ev(0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        cyc(1'b0, 1'b1, 2'h2, 32'h2002, 32'h0, 1'b0);
        ev(0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        $display("test fetch break done");
        wr(bmbt_pkg::ADDR_CTRL, 32'h6000);
        wr(ch(3, bmbt_pkg::CH_ADDR), 32'h3000);
        wr(ch(3, bmbt_pkg::CH_AMASK), 32'hf0);
        wr(ch(3, bmbt_pkg::CH_DATA), 32'h12345678);
        wr(ch(3, bmbt_pkg::CH_DMASK), 32'hffffff00);
        wr(ch(3, bmbt_pkg::CH_COUNT), 32'h2);
        wr(ch(3, bmbt_pkg::CH_CYCLE), 32'h19);
        cyc(1'b0, 1'b0, 2'h3, 32'h3050, 32'h77, 1'b0);
        cyc(1'b0, 1'b0, 2'h3, 32'h3050, 32'habcdef78, 1'b0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h0);
        cyc(1'b0, 1'b0, 2'h3, 32'h3050, 32'habcdef78, 1'b0);
        rdc(bmbt_pkg::ADDR_FLAGS, 32'h8);
        $display("test count break done");
        report_and_stop();
    end
endmodule
